// File: design/rsq_pkg.sv
package rsq_pkg;

  // bus geometry: each register index takes one 32-bit word, byte address = 4 * index
  localparam int unsigned ADR_W = 18;
  localparam int unsigned IDX_W = 16;

  // register indices
  localparam logic [IDX_W-1:0] IDX_CHIRP_LEVEL = 16'hFE31;
  localparam logic [IDX_W-1:0] IDX_RSSI_LOW    = 16'hFE33;
  localparam logic [IDX_W-1:0] IDX_RSSI_MEAN   = 16'hFE34;
  localparam logic [IDX_W-1:0] IDX_RSSI_PEAK   = 16'hFE35;
  localparam logic [IDX_W-1:0] IDX_CINR_LOW    = 16'hFE38;
  localparam logic [IDX_W-1:0] IDX_CINR_MEAN   = 16'hFE39;
  localparam logic [IDX_W-1:0] IDX_CINR_PEAK   = 16'hFE3A;
  localparam logic [IDX_W-1:0] IDX_EVM_HDR     = 16'hFE3B;
  localparam logic [IDX_W-1:0] IDX_EVM_PAY     = 16'hFE3D;
  localparam logic [IDX_W-1:0] IDX_EVM_SUM     = 16'hFE3F;
  localparam logic [IDX_W-1:0] IDX_CTRL        = 16'hFE80;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 16'hFE81;

  // field widths and positions
  localparam int unsigned LVL_W          = 8;
  localparam int unsigned EVM_W          = 16;
  localparam int unsigned SUM_W          = 20;
  localparam int unsigned SUM_LSB        = 12;
  localparam int unsigned EVM_FRAC_W     = 9;
  localparam int unsigned SYM_W          = 16;
  localparam int unsigned CTRL_MODE_BIT  = 0;
  localparam int unsigned STAT_MODE_BIT  = 0;
  localparam int unsigned STAT_READY_BIT = 1;
  // one mismatched reference bit costs 1 dB, i.e. 4 quarter-dB steps
  localparam int unsigned NOISE_SHIFT    = 2;

  // reset values
  localparam logic [LVL_W-1:0] RST_LVL_LOW  = 8'hFF;
  localparam logic [LVL_W-1:0] RST_LVL_ZERO = 8'h00;
  localparam logic [EVM_W-1:0] RST_EVM      = 16'h0000;
  localparam logic [SUM_W-1:0] RST_SUM      = 20'h00000;

  // reception path strobes, one cycle each
  typedef struct packed {
    logic             msg_start;
    logic             chirp_valid;
    logic [15:0]      chirp_level;
    logic             sym_valid;
    logic             beacon;
    logic [LVL_W-1:0] rssi;
    logic [SYM_W-1:0] sym_word;
    logic             car_valid;
    logic             car_header;
    logic             car_last;
    logic [EVM_W-1:0] car_evm;
  } rsq_rx_s;

  // beacon submission words, and the same words passed on to the line
  typedef struct packed {
    logic             valid;
    logic             last;
    logic [SYM_W-1:0] data;
  } rsq_tx_s;

endpackage : rsq_pkg

// File: design/rsq_regs.sv
`timescale 1ns/1ps
// Function
// - chirp autocorrelation level captured as 16-bit read-only value when reception starts.
// - lowest per-symbol signal strength of last message, 8 bits, resets to all ones.
// - average signal strength of last message, 8 bits, resets to zero.
// - highest signal strength of last message, 8 bits, resets to zero.
// - strength sampled once per symbol; stored values in quarter-dB steps.
// - lowest per-symbol noise ratio of last message, quarter dB, resets to all ones.
// - average per-symbol noise ratio of last message, quarter dB, resets to zero.
// - highest per-symbol noise ratio of last message, quarter dB, resets to zero.
// - noise ratio compares received beacon symbols with the stored reference table.
// - in reference-load mode submitted beacon words fill the table, not the line.
// - table loading completes in microseconds, one word per clock.
// - peak header error vector magnitude kept as 16 bits, resets to zero.
// - peak payload error vector magnitude kept as 16 bits, resets to zero.
// - magnitude fixed point: top 7 bits integer percent, low 9 bits fraction.
// - per header symbol sum carrier magnitudes; keep largest sum as 20 bits.
// - 20-bit sum sits in top of a 32-bit word, low 12 bits zero.
module rsq_regs #(
  parameter int unsigned TAB_DEPTH = 64,
  parameter int unsigned CNT_W     = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [rsq_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire rsq_pkg::rsq_rx_s         rx_i,
  input  wire rsq_pkg::rsq_tx_s         tx_i,
  output rsq_pkg::rsq_tx_s              line_tx_o
);

  localparam int unsigned TAB_AW = (TAB_DEPTH > 1) ? $clog2(TAB_DEPTH) : 1;
  localparam int unsigned ACC_W  = CNT_W + rsq_pkg::LVL_W;

  // sum of mismatching bits between a received and a reference word
  function automatic logic [4:0] mismatch_f(input logic [rsq_pkg::SYM_W-1:0] a,
                                            input logic [rsq_pkg::SYM_W-1:0] b);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < rsq_pkg::SYM_W; i++) begin
      n = n + {4'h0, a[i] ^ b[i]};
    end
    return n;
  endfunction : mismatch_f

  // mean of an accumulated sum, count zero at the call sites only once the CNT_W-bit counter wraps
  function automatic logic [rsq_pkg::LVL_W-1:0] mean_f(input logic [ACC_W-1:0] s,
                                                       input logic [CNT_W-1:0] n);
    logic [ACC_W-1:0] q;
    q = s / {{rsq_pkg::LVL_W{1'b0}}, n};
    return q[rsq_pkg::LVL_W-1:0];
  endfunction : mean_f

  // registers
  logic [15:0]                chirp_level;
  logic [rsq_pkg::LVL_W-1:0]  rssi_low, rssi_mean, rssi_peak;
  logic [rsq_pkg::LVL_W-1:0]  cinr_low, cinr_mean, cinr_peak;
  logic [rsq_pkg::EVM_W-1:0]  evm_hdr_peak, evm_pay_peak;
  logic [rsq_pkg::SUM_W-1:0]  evm_sum_peak;
  logic                       load_mode;
  logic                       table_ready;

  // working state
  logic [ACC_W-1:0]           rssi_acc, cinr_acc;
  logic [CNT_W-1:0]           rssi_cnt, cinr_cnt;
  logic [rsq_pkg::SUM_W-1:0]  evm_sum;
  logic [TAB_AW-1:0]          load_ptr, sym_idx;
  logic [rsq_pkg::SYM_W-1:0]  ref_tab [TAB_DEPTH];

  logic                       bus_req;
  logic [rsq_pkg::IDX_W-1:0]  bus_idx;
  logic [31:0]                next_dat;
  logic                       cinr_take;
  logic [rsq_pkg::LVL_W-1:0]  cinr_now;
  logic [6:0]                 noise_q;
  logic [ACC_W-1:0]           next_rssi_acc, next_cinr_acc;
  logic [CNT_W-1:0]           next_rssi_cnt, next_cinr_cnt;
  logic [rsq_pkg::SUM_W-1:0]  next_evm_sum;
  logic [rsq_pkg::SUM_W:0]    evm_add;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_idx = wb_adr_i[rsq_pkg::ADR_W-1:2];

  // wishbone slave: one wait state, ack pulses for one cycle, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // read decode; narrow registers sit in the low bits, except the sum, which sits in the top bits
  always_comb begin
    next_dat = 32'h00000000;
    unique case (bus_idx)
      rsq_pkg::IDX_CHIRP_LEVEL: next_dat[15:0] = chirp_level;
      rsq_pkg::IDX_RSSI_LOW:    next_dat[7:0]  = rssi_low;
      rsq_pkg::IDX_RSSI_MEAN:   next_dat[7:0]  = rssi_mean;
      rsq_pkg::IDX_RSSI_PEAK:   next_dat[7:0]  = rssi_peak;
      rsq_pkg::IDX_CINR_LOW:    next_dat[7:0]  = cinr_low;
      rsq_pkg::IDX_CINR_MEAN:   next_dat[7:0]  = cinr_mean;
      rsq_pkg::IDX_CINR_PEAK:   next_dat[7:0]  = cinr_peak;
      rsq_pkg::IDX_EVM_HDR:     next_dat[15:0] = evm_hdr_peak;
      rsq_pkg::IDX_EVM_PAY:     next_dat[15:0] = evm_pay_peak;
      // msb-aligned sum; the low bits below it always read as zero
      rsq_pkg::IDX_EVM_SUM:     next_dat[31:rsq_pkg::SUM_LSB] = evm_sum_peak;
      rsq_pkg::IDX_CTRL:        next_dat[rsq_pkg::CTRL_MODE_BIT] = load_mode;
      rsq_pkg::IDX_STATUS: begin
        next_dat[rsq_pkg::STAT_MODE_BIT]  = load_mode;
        next_dat[rsq_pkg::STAT_READY_BIT] = table_ready;
      end
      default:                  next_dat = 32'h00000000;
    endcase
  end

  // only the control word is writable, at the edge where the master sees ack;
  // measurement words drop writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_mode <= 1'b0;
    end else if (ce_i && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
                 && bus_idx == rsq_pkg::IDX_CTRL) begin
      load_mode <= wb_dat_i[rsq_pkg::CTRL_MODE_BIT];
    end
  end

  // reference table fill: one word per clock, so a beacon loads in microseconds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_ptr <= '0;
    end else if (ce_i) begin
      if (!load_mode) begin
        load_ptr <= '0;
      end else if (tx_i.valid) begin
        load_ptr <= load_ptr + 1'b1;
      end
    end
  end

  // table storage has no reset; table_ready guards its use
  always_ff @(posedge clk_i) begin
    if (ce_i && load_mode && tx_i.valid) begin
      ref_tab[load_ptr] <= tx_i.data;
    end
  end

  // ready once the last word lands; a new load invalidates it, the final word wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      table_ready <= 1'b0;
    end else if (ce_i) begin
      if (load_mode && tx_i.valid && tx_i.last) begin
        table_ready <= 1'b1;
      end else if (load_mode && tx_i.valid && load_ptr == '0) begin
        table_ready <= 1'b0;
      end
    end
  end

  // words are diverted from the line while loading
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_tx_o <= '0;
    end else if (ce_i) begin
      line_tx_o       <= tx_i;
      line_tx_o.valid <= tx_i.valid & ~load_mode;
    end
  end

  // chirp level follows the correlator at the start of reception
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chirp_level <= 16'h0000;
    end else if (ce_i && rx_i.chirp_valid) begin
      chirp_level <= rx_i.chirp_level;
    end
  end

  assign next_rssi_acc = rssi_acc + {{CNT_W{1'b0}}, rx_i.rssi};
  assign next_rssi_cnt = rssi_cnt + 1'b1;

  // signal strength, one sample per symbol in quarter dB
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rssi_low  <= rsq_pkg::RST_LVL_LOW;
      rssi_mean <= rsq_pkg::RST_LVL_ZERO;
      rssi_peak <= rsq_pkg::RST_LVL_ZERO;
      rssi_acc  <= '0;
      rssi_cnt  <= '0;
    end else if (ce_i) begin
      if (rx_i.msg_start) begin
        rssi_low  <= rsq_pkg::RST_LVL_LOW;
        rssi_mean <= rsq_pkg::RST_LVL_ZERO;
        rssi_peak <= rsq_pkg::RST_LVL_ZERO;
        rssi_acc  <= '0;
        rssi_cnt  <= '0;
      end else if (rx_i.sym_valid) begin
        if (rx_i.rssi < rssi_low) rssi_low <= rx_i.rssi;
        if (rx_i.rssi > rssi_peak) rssi_peak <= rx_i.rssi;
        rssi_mean <= mean_f(next_rssi_acc, next_rssi_cnt);
        rssi_acc  <= next_rssi_acc;
        rssi_cnt  <= next_rssi_cnt;
      end
    end
  end

  // beacon symbol position walks the reference table
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sym_idx <= '0;
    end else if (ce_i) begin
      if (rx_i.msg_start) begin
        sym_idx <= '0;
      end else if (rx_i.sym_valid && rx_i.beacon) begin
        sym_idx <= sym_idx + 1'b1;
      end
    end
  end

  // noise from bits that differ from the reference; crude but cheap, no soft metrics
  assign noise_q   = {2'b00, mismatch_f(rx_i.sym_word, ref_tab[sym_idx])} << rsq_pkg::NOISE_SHIFT;
  assign cinr_now  = (rx_i.rssi > {1'b0, noise_q}) ? rx_i.rssi - {1'b0, noise_q}
                                                   : rsq_pkg::RST_LVL_ZERO;
  assign cinr_take = rx_i.sym_valid & rx_i.beacon & table_ready & ~load_mode;

  assign next_cinr_acc = cinr_acc + {{CNT_W{1'b0}}, cinr_now};
  assign next_cinr_cnt = cinr_cnt + 1'b1;

  // noise ratio statistics over beacon symbols only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cinr_low  <= rsq_pkg::RST_LVL_LOW;
      cinr_mean <= rsq_pkg::RST_LVL_ZERO;
      cinr_peak <= rsq_pkg::RST_LVL_ZERO;
      cinr_acc  <= '0;
      cinr_cnt  <= '0;
    end else if (ce_i) begin
      if (rx_i.msg_start) begin
        cinr_low  <= rsq_pkg::RST_LVL_LOW;
        cinr_mean <= rsq_pkg::RST_LVL_ZERO;
        cinr_peak <= rsq_pkg::RST_LVL_ZERO;
        cinr_acc  <= '0;
        cinr_cnt  <= '0;
      end else if (cinr_take) begin
        if (cinr_now < cinr_low) cinr_low <= cinr_now;
        if (cinr_now > cinr_peak) cinr_peak <= cinr_now;
        cinr_mean <= mean_f(next_cinr_acc, next_cinr_cnt);
        cinr_acc  <= next_cinr_acc;
        cinr_cnt  <= next_cinr_cnt;
      end
    end
  end

  // saturating carrier sum so a noisy symbol cannot wrap to a small value
  assign evm_add      = {1'b0, evm_sum} + {5'h00, rx_i.car_evm};
  assign next_evm_sum = evm_add[rsq_pkg::SUM_W] ? {rsq_pkg::SUM_W{1'b1}}
                                                : evm_add[rsq_pkg::SUM_W-1:0];

  // per-carrier peaks and per-header-symbol sum peak
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evm_hdr_peak <= rsq_pkg::RST_EVM;
      evm_pay_peak <= rsq_pkg::RST_EVM;
      evm_sum_peak <= rsq_pkg::RST_SUM;
      evm_sum      <= rsq_pkg::RST_SUM;
    end else if (ce_i) begin
      if (rx_i.msg_start) begin
        evm_hdr_peak <= rsq_pkg::RST_EVM;
        evm_pay_peak <= rsq_pkg::RST_EVM;
        evm_sum_peak <= rsq_pkg::RST_SUM;
        evm_sum      <= rsq_pkg::RST_SUM;
      end else if (rx_i.car_valid) begin
        if (rx_i.car_header) begin
          if (rx_i.car_evm > evm_hdr_peak) evm_hdr_peak <= rx_i.car_evm;
          if (rx_i.car_last) begin
            evm_sum <= rsq_pkg::RST_SUM;
            if (next_evm_sum > evm_sum_peak) evm_sum_peak <= next_evm_sum;
          end else begin
            evm_sum <= next_evm_sum;
          end
        end else if (rx_i.car_evm > evm_pay_peak) begin
          evm_pay_peak <= rx_i.car_evm;
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_chirp;
    ce_i && rx_i.chirp_valid |=> chirp_level == $past(rx_i.chirp_level);
  endproperty
  a_chirp: assert property (p_chirp) else $error("chirp level not captured");

  property p_restart;
    ce_i && rx_i.msg_start |=> rssi_low == 8'hFF && rssi_peak == 8'h00 && cinr_low == 8'hFF
                               && evm_hdr_peak == 16'h0000 && evm_sum_peak == 20'h00000;
  endproperty
  a_restart: assert property (p_restart) else $error("measurements not restarted");

  property p_rssi_order;
    rssi_cnt != '0 |-> rssi_low <= rssi_mean && rssi_mean <= rssi_peak;
  endproperty
  a_rssi_order: assert property (p_rssi_order) else $error("strength min/avg/max order");

  property p_rssi_sample;
    ce_i && rx_i.sym_valid && !rx_i.msg_start
      |=> rssi_low <= $past(rx_i.rssi) && rssi_peak >= $past(rx_i.rssi);
  endproperty
  a_rssi_sample: assert property (p_rssi_sample) else $error("strength extremes missed");

  property p_cinr_sample;
    ce_i && cinr_take && !rx_i.msg_start
      |=> cinr_low <= $past(cinr_now) && cinr_peak >= $past(cinr_now) && cinr_cnt != '0;
  endproperty
  a_cinr_sample: assert property (p_cinr_sample) else $error("noise ratio extremes missed");

  property p_divert;
    ce_i && load_mode && tx_i.valid
      |=> !line_tx_o.valid && ref_tab[$past(load_ptr)] == $past(tx_i.data);
  endproperty
  a_divert: assert property (p_divert) else $error("loaded word reached the line");

  property p_load_done;
    ce_i && load_mode && tx_i.valid && tx_i.last |=> table_ready;
  endproperty
  a_load_done: assert property (p_load_done) else $error("table not ready after last word");

  property p_evm_peak;
    ce_i && rx_i.car_valid && !rx_i.msg_start |=>
      (($past(rx_i.car_header) ? evm_hdr_peak : evm_pay_peak) >= $past(rx_i.car_evm));
  endproperty
  a_evm_peak: assert property (p_evm_peak) else $error("vector error peak missed");

  property p_sum_low;
    ce_i && bus_req && !wb_we_i && bus_idx == rsq_pkg::IDX_EVM_SUM
      |=> wb_ack_o && wb_dat_o[11:0] == 12'h000;
  endproperty
  a_sum_low: assert property (p_sum_low) else $error("sum word low bits not zero");

  property p_read_only;
    ce_i && bus_req && wb_we_i && !rx_i.msg_start && !rx_i.sym_valid && !rx_i.car_valid
      |=> $stable(rssi_low) && $stable(cinr_peak) && $stable(evm_sum_peak);
  endproperty
  a_read_only: assert property (p_read_only) else $error("write changed a measurement");

  c_load:  cover property (ce_i && load_mode && tx_i.valid && tx_i.last);
  c_cinr:  cover property (ce_i && cinr_take && !rx_i.msg_start);
  c_hsum:  cover property (ce_i && rx_i.car_valid && rx_i.car_header && rx_i.car_last);
  c_read:  cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h00000000);

endmodule : rsq_regs

// File: tb/rsq_regs_tb.sv
`timescale 1ns/1ps
module testbench;
  logic                        clk_i;
  logic                        rst_i;
  logic                        ce;
  logic                        wb_cyc_i;
  logic                        wb_stb_i;
  logic                        wb_we_i;
  logic [rsq_pkg::ADR_W-1:0]   wb_adr_i;
  logic [3:0]                  wb_sel_i;
  logic [31:0]                 wb_dat_i;
  logic [31:0]                 wb_dat_o;
  logic                        wb_ack_o;
  rsq_pkg::rsq_rx_s            rx;
  rsq_pkg::rsq_tx_s            tx;
  rsq_pkg::rsq_tx_s            line_tx;
  int                          failures = 0;
  int                          tests_run = 0;
  logic [31:0]                 rd;

  // clock enable is driven so that a frozen stretch can be checked
  rsq_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx), .tx_i(tx),
    .line_tx_o(line_tx));

  // 40 MHz clock
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task wb_cycle(input logic [15:0] idx, input logic we, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle

  task rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    wb_cycle(idx, 1'b0, 32'h0);
    check(rd, exp, what);
  endtask : rd_chk

  // single-cycle strobe on the reception path, then idle
  task rx_pulse(input rsq_pkg::rsq_rx_s v);
    @(posedge clk_i);
    rx <= v;
    @(posedge clk_i);
    rx <= '0;
  endtask : rx_pulse

  task msg_start;
    rsq_pkg::rsq_rx_s v;
    v = '0;
    v.msg_start = 1'b1;
    rx_pulse(v);
  endtask : msg_start

  task sym(input logic [7:0] rssi, input logic bcn, input logic [15:0] w);
    rsq_pkg::rsq_rx_s v;
    v = '0;
    v.sym_valid = 1'b1;
    v.rssi = rssi;
    v.beacon = bcn;
    v.sym_word = w;
    rx_pulse(v);
  endtask : sym

  task car(input logic hdr, input logic last, input logic [15:0] evm);
    rsq_pkg::rsq_rx_s v;
    v = '0;
    v.car_valid = 1'b1;
    v.car_header = hdr;
    v.car_last = last;
    v.car_evm = evm;
    rx_pulse(v);
  endtask : car

  // one submitted word; line copy is checked just after the edge that takes it
  task tx_word(input logic last, input logic [15:0] d, input logic exp_valid);
    @(posedge clk_i);
    tx <= '{valid: 1'b1, last: last, data: d};
    @(posedge clk_i);
    tx <= '0;
    #1;
    check({31'h0, line_tx.valid}, {31'h0, exp_valid}, "line valid");
    check({31'h0, line_tx.last}, {31'h0, last}, "line last");
    if (exp_valid) check({16'h0, line_tx.data}, {16'h0, d}, "line data");
  endtask : tx_word

  task test_reset;
    rd_chk(rsq_pkg::IDX_CHIRP_LEVEL, 32'h0000_0000, "chirp rst");
    rd_chk(rsq_pkg::IDX_RSSI_LOW, 32'h0000_00FF, "rssi low rst");
    rd_chk(rsq_pkg::IDX_RSSI_MEAN, 32'h0000_0000, "rssi mean rst");
    rd_chk(rsq_pkg::IDX_RSSI_PEAK, 32'h0000_0000, "rssi peak rst");
    rd_chk(rsq_pkg::IDX_CINR_LOW, 32'h0000_00FF, "cinr low rst");
    rd_chk(rsq_pkg::IDX_CINR_MEAN, 32'h0000_0000, "cinr mean rst");
    rd_chk(rsq_pkg::IDX_CINR_PEAK, 32'h0000_0000, "cinr peak rst");
    rd_chk(rsq_pkg::IDX_EVM_HDR, 32'h0000_0000, "evm hdr rst");
    rd_chk(rsq_pkg::IDX_EVM_PAY, 32'h0000_0000, "evm pay rst");
    rd_chk(rsq_pkg::IDX_EVM_SUM, 32'h0000_0000, "evm sum rst");
    rd_chk(16'hFE50, 32'h0000_0000, "unmapped read");
    $display("reset values done");
  endtask : test_reset

  task test_strength;
    rsq_pkg::rsq_rx_s v;
    msg_start();
    v = '0;
    v.chirp_valid = 1'b1;
    v.chirp_level = 16'hBEEF;
    rx_pulse(v);
    sym(8'h40, 1'b0, 16'h0000);
    sym(8'h20, 1'b0, 16'h0000);
    sym(8'h60, 1'b0, 16'h0000);
    rd_chk(rsq_pkg::IDX_CHIRP_LEVEL, 32'h0000_BEEF, "chirp level");
    rd_chk(rsq_pkg::IDX_RSSI_LOW, 32'h0000_0020, "rssi low");
    rd_chk(rsq_pkg::IDX_RSSI_MEAN, 32'h0000_0040, "rssi mean");
    rd_chk(rsq_pkg::IDX_RSSI_PEAK, 32'h0000_0060, "rssi peak");
    // software writes must not disturb the stored figures
    wb_cycle(rsq_pkg::IDX_RSSI_LOW, 1'b1, 32'hFFFF_FFFF);
    wb_cycle(rsq_pkg::IDX_CHIRP_LEVEL, 1'b1, 32'h0000_0000);
    rd_chk(rsq_pkg::IDX_RSSI_LOW, 32'h0000_0020, "low after write");
    rd_chk(rsq_pkg::IDX_CHIRP_LEVEL, 32'h0000_BEEF, "chirp after wr");
    // a symbol that arrives while the clock enable is low must change nothing
    ce <= 1'b0;
    sym(8'h01, 1'b0, 16'h0000);
    ce <= 1'b1;
    rd_chk(rsq_pkg::IDX_RSSI_LOW, 32'h0000_0020, "low frozen");
    rd_chk(rsq_pkg::IDX_RSSI_MEAN, 32'h0000_0040, "mean frozen");
    $display("signal strength done");
  endtask : test_strength

  task test_evm;
    msg_start();
    car(1'b1, 1'b0, 16'h0100);
    car(1'b1, 1'b1, 16'h0200);
    car(1'b1, 1'b0, 16'h0300);
    car(1'b1, 1'b1, 16'h0200);
    car(1'b0, 1'b0, 16'h6401);
    car(1'b0, 1'b0, 16'h0200);
    rd_chk(rsq_pkg::IDX_EVM_HDR, 32'h0000_0300, "evm hdr peak");
    rd_chk(rsq_pkg::IDX_EVM_PAY, 32'h0000_6401, "evm pay peak");
    rd_chk(rsq_pkg::IDX_EVM_SUM, 32'h0050_0000, "evm sum peak");
    wb_cycle(rsq_pkg::IDX_EVM_SUM, 1'b1, 32'h0000_0FFF);
    rd_chk(rsq_pkg::IDX_EVM_SUM, 32'h0050_0000, "sum after write");
    // a new message must drop the old peaks
    msg_start();
    car(1'b1, 1'b1, 16'h0010);
    rd_chk(rsq_pkg::IDX_EVM_HDR, 32'h0000_0010, "hdr after restart");
    rd_chk(rsq_pkg::IDX_EVM_SUM, 32'h0001_0000, "sum after restart");
    $display("vector error done");
  endtask : test_evm

  task test_reference;
    tx_word(1'b1, 16'h1357, 1'b1);
    wb_cycle(rsq_pkg::IDX_CTRL, 1'b1, 32'h0000_0001);
    rd_chk(rsq_pkg::IDX_CTRL, 32'h0000_0001, "mode readback");
    tx_word(1'b0, 16'hA5A5, 1'b0);
    tx_word(1'b1, 16'h0F0F, 1'b0);
    wb_cycle(rsq_pkg::IDX_STATUS, 1'b0, 32'h0);
    check(rd & 32'h3, 32'h3, "table ready in mode");
    wb_cycle(rsq_pkg::IDX_CTRL, 1'b1, 32'h0000_0000);
    wb_cycle(rsq_pkg::IDX_STATUS, 1'b0, 32'h0);
    check(rd & 32'h3, 32'h2, "mode off ready kept");
    msg_start();
    sym(8'h40, 1'b1, 16'hA5A5);
    sym(8'h40, 1'b1, 16'h0F0E);
    rd_chk(rsq_pkg::IDX_CINR_LOW, 32'h0000_003C, "cinr low");
    rd_chk(rsq_pkg::IDX_CINR_MEAN, 32'h0000_003E, "cinr mean");
    rd_chk(rsq_pkg::IDX_CINR_PEAK, 32'h0000_0040, "cinr peak");
    msg_start();
    sym(8'h10, 1'b0, 16'h0000);
    rd_chk(rsq_pkg::IDX_RSSI_LOW, 32'h0000_0010, "low restart");
    rd_chk(rsq_pkg::IDX_RSSI_MEAN, 32'h0000_0010, "mean restart");
    rd_chk(rsq_pkg::IDX_RSSI_PEAK, 32'h0000_0010, "peak restart");
    $display("reference table done");
  endtask : test_reference

  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    rst_i    = 1'b1;
    ce       = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = '0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rx       = '0;
    tx       = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_strength();
    test_evm();
    test_reference();
    give_verdict();
  end
endmodule : testbench
